// [pkg/led_matrix_defs.vh]
// Constants for the LED matrix scanner and register block
`ifndef LED_MATRIX_DEFS_VH
`define LED_MATRIX_DEFS_VH

// ============================================================
// Register pages (upper address bits of the host register port)
`define PAGE_PWM        2'h1
`define PAGE_PATTERN    2'h2
`define PAGE_FUNC       2'h3

// ============================================================
// Function page offsets
`define OFF_CONFIG      8'h00
`define OFF_GCS         8'h01
`define OFF_TIME_FIRST  8'h02
`define OFF_TIME_LAST   8'h0d
`define OFF_COMMIT      8'h0e
`define OFF_PULLUP      8'h0f
`define OFF_PULLDOWN    8'h10
`define OFF_RESET       8'h11
`define DOT_LAST        8'hbf

// ============================================================
// Fields and reset values
`define CFG_BREATH_EN   1
`define SEL_MSB         2
`define COMMIT_CODE     8'h00
`define CONFIG_RST      8'h00
`define GCS_RST         8'h00
`define TIME_RST        8'h00
`define SEL_RST         3'h0
`define PAT_PWM         2'h0

// ============================================================
// Timing: figures in ns, counts derived at the clock rate
`define CLK_NS          40
`define SLOT_NS         128000
`define NOL_NS          8000
`define SLOT_CYC        ((`SLOT_NS + `CLK_NS - 1) / `CLK_NS)
`define NOL_CYC         ((`NOL_NS + `CLK_NS - 1) / `CLK_NS)
`define PWM_STEPS       256
`define PWM_PRE         (`SLOT_CYC / `PWM_STEPS)

`endif

// [hdl/dot_mem.v]
// Per-dot storage with one write port and a registered read port
`timescale 1ns/1ns

module dot_mem #(
    parameter WIDTH = 8,
    parameter DEPTH = 192,
    parameter AW    = 8
) (
    input  wire             clk,
    input  wire             we,
    input  wire [AW-1:0]    waddr,
    input  wire [WIDTH-1:0] wdata,
    input  wire [AW-1:0]    raddr,
    output reg  [WIDTH-1:0] rdata
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // ============================================================
    // Write and registered read; no reset, owner sweeps it clear
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule // dot_mem

// [hdl/led_matrix_scan_pwm.v]
// Matrix scanner, per-dot PWM and function registers of the LED driver
// Function
// - Time register writes go to shadow copies, not the active set.
// - Writing zero to commit register copies shadow times into active.
// - Column pull-up code in bits 2:0, 000 none, only during blanking.
// - Row pull-down code, 000 off, others only during blanking.
// - Host read of reset register returns all registers to defaults.
// - After power-up all registers hold defaults, matrix blank; column 0's first slot shows pre-sweep dot memory.
// - Twelve column switches enabled in turn, sixteen rows per column.
// - Each slot lasts 128 us, then 8 us blanking with no switch.
// - Each switch on for one in 12.75 of the frame.
// - Dot current is PWM over 256 times output current times duty.
// - Global scale value sets all row currents as value over 256.
// - Each dot runs independently in PWM or breathing mode.
// - Dot is PWM when its pattern is 00 or breathing disabled.
// - PWM value is a plain binary brightness step index.
// - PWM updates accepted any time except during the clear sweep, and applied to the output.
// - Clearing breath enable disables breathing for every dot.
`timescale 1ns/1ns
`include "led_matrix_defs.vh"

module led_matrix_scan_pwm #(
    parameter COLS = 12,
    parameter ROWS = 16
) (
    input  wire                clk,
    input  wire                rst_n,
    input  wire [9:0]          reg_addr,
    input  wire [7:0]          reg_wdata,
    input  wire                reg_wr,
    input  wire                reg_rd,
    output reg  [7:0]          reg_rdata,
    input  wire [23:0]         breath_level,
    output reg  [95:0]         breath_time_active,
    output reg  [7:0]          config_value,
    output reg  [7:0]          global_current_scale,
    output reg  [COLS-1:0]     column_switch,
    output reg  [ROWS-1:0]     row_current_source,
    output reg  [2:0]          switch_pullup_select,
    output reg  [2:0]          source_pulldown_select
);

    localparam ST_NOL  = 1'b0;
    localparam ST_SLOT = 1'b1;
    localparam NDOTS   = COLS * ROWS;
    localparam integer COL_LAST = COLS - 1;

    // ============================================================
    // Helpers
    function is_time_off;
        input [7:0] off;
        begin
            is_time_off = (off >= `OFF_TIME_FIRST) &&
                          (off <= `OFF_TIME_LAST);
        end
    endfunction

    function [7:0] dot_level;
        input [7:0]  pwm;
        input [1:0]  pat;
        input        b_en;
        input [23:0] lvl;
        begin
            if (!b_en || pat == `PAT_PWM) begin
                dot_level = pwm;
            end else begin
                dot_level = lvl[(pat - 2'h1) * 8 +: 8];
            end
        end
    endfunction

    // ============================================================
    // Reset release through two flops
    reg rst_m_r;
    reg rst_s_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end

    // ============================================================
    // Register port decode
    wire [1:0] page   = reg_addr[9:8];
    wire [7:0] off    = reg_addr[7:0];
    wire       func_w = reg_wr && page == `PAGE_FUNC;
    wire       soft_clr = reg_rd && page == `PAGE_FUNC &&
                          off == `OFF_RESET;
    wire       commit = func_w && off == `OFF_COMMIT &&
                        reg_wdata == `COMMIT_CODE;

    reg [95:0] shadow_r;

    // Shadow and active time bytes, one generate lane per byte
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1) begin : g_time
            always @(posedge clk or negedge rst_s_r) begin
                if (!rst_s_r) begin
                    shadow_r[gi*8 +: 8]           <= `TIME_RST;
                    breath_time_active[gi*8 +: 8] <= `TIME_RST;
                end else if (soft_clr) begin
                    shadow_r[gi*8 +: 8]           <= `TIME_RST;
                    breath_time_active[gi*8 +: 8] <= `TIME_RST;
                end else begin
                    if (func_w && off == `OFF_TIME_FIRST + gi) begin
                        shadow_r[gi*8 +: 8] <= reg_wdata;
                    end
                    // All lanes copy on the same edge
                    if (commit) begin
                        breath_time_active[gi*8 +: 8] <=
                            shadow_r[gi*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    reg [2:0] pullup_r;
    reg [2:0] pulldown_r;

    // Function registers; read-to-reset beats any write
    always @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            config_value         <= `CONFIG_RST;
            global_current_scale <= `GCS_RST;
            pullup_r             <= `SEL_RST;
            pulldown_r           <= `SEL_RST;
        end else if (soft_clr) begin
            config_value         <= `CONFIG_RST;
            global_current_scale <= `GCS_RST;
            pullup_r             <= `SEL_RST;
            pulldown_r           <= `SEL_RST;
        end else if (func_w) begin
            case (off)
                `OFF_CONFIG:   config_value <= reg_wdata;
                `OFF_GCS:      global_current_scale <= reg_wdata;
                `OFF_PULLUP:   pullup_r <= reg_wdata[`SEL_MSB:0];
                `OFF_PULLDOWN: pulldown_r <= reg_wdata[`SEL_MSB:0];
                default:       pullup_r <= pullup_r;
            endcase
        end
    end

    // Read data, one cycle after the strobe
    always @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (page != `PAGE_FUNC) begin
                reg_rdata <= 8'h00;
            end else if (is_time_off(off)) begin
                reg_rdata <= shadow_r[(off - `OFF_TIME_FIRST) * 8 +: 8];
            end else begin
                case (off)
                    `OFF_CONFIG:   reg_rdata <= config_value;
                    `OFF_GCS:      reg_rdata <= global_current_scale;
                    `OFF_PULLUP:   reg_rdata <= {5'h00, pullup_r};
                    `OFF_PULLDOWN: reg_rdata <= {5'h00, pulldown_r};
                    default:       reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ============================================================
    // Dot memory clear sweep after any reset; rows held dark only while it runs
    reg       clr_busy_r;
    reg [7:0] clr_addr_r;
    always @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            clr_busy_r <= 1'b1;
            clr_addr_r <= 8'h00;
        end else if (soft_clr) begin
            clr_busy_r <= 1'b1;
            clr_addr_r <= 8'h00;
        end else if (clr_busy_r) begin
            clr_addr_r <= clr_addr_r + 8'h01;
            if (clr_addr_r == `DOT_LAST) begin
                clr_busy_r <= 1'b0;
            end
        end
    end

    // Host writes land any time; lost during the sweep or at offsets above DOT_LAST
    wire       dot_ok = !clr_busy_r && off <= `DOT_LAST;
    wire       pwm_we = clr_busy_r ||
                        (reg_wr && page == `PAGE_PWM && dot_ok);
    wire       pat_we = clr_busy_r ||
                        (reg_wr && page == `PAGE_PATTERN && dot_ok);
    wire [7:0] mem_waddr = clr_busy_r ? clr_addr_r : off;
    wire [7:0] pwm_wdata = clr_busy_r ? 8'h00 : reg_wdata;
    wire [1:0] pat_wdata = clr_busy_r ? `PAT_PWM : reg_wdata[1:0];

    // ============================================================
    // Scan timing
    reg        state_r;
    reg [11:0] cnt_r;
    reg [3:0]  col_r;
    reg [3:0]  pre_r;
    reg [8:0]  step_r;
    wire [3:0] next_col = (col_r == COLS - 1) ? 4'h0 : col_r + 4'h1;

    always @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            state_r <= ST_NOL;
            cnt_r   <= 12'h000;
            col_r   <= COL_LAST[3:0];
            pre_r   <= 4'h0;
            step_r  <= 9'h000;
        end else begin
            case (state_r)
                ST_NOL: begin
                    cnt_r <= cnt_r + 12'h001;
                    if (cnt_r == `NOL_CYC - 1) begin
                        state_r <= ST_SLOT;
                        cnt_r   <= 12'h000;
                        col_r   <= next_col;
                        pre_r   <= 4'h0;
                        step_r  <= 9'h000;
                    end
                end
                ST_SLOT: begin
                    cnt_r <= cnt_r + 12'h001;
                    // Step counter spans 256*12 cycles; rest of slot dark
                    if (pre_r == `PWM_PRE - 1) begin
                        pre_r <= 4'h0;
                        if (!step_r[8]) begin
                            step_r <= step_r + 9'h001;
                        end
                    end else begin
                        pre_r <= pre_r + 4'h1;
                    end
                    if (cnt_r == `SLOT_CYC - 1) begin
                        state_r <= ST_NOL;
                        cnt_r   <= 12'h000;
                    end
                end
                default: state_r <= ST_NOL;
            endcase
        end
    end

    // ============================================================
    // Fetch next column's sixteen dots during blanking
    wire [7:0] rd_addr = {next_col, cnt_r[3:0]};
    wire [7:0] pwm_q;
    wire [1:0] pat_q;

    dot_mem #(.WIDTH(8), .DEPTH(NDOTS), .AW(8)) u_pwm_mem (
        .clk   (clk),
        .we    (pwm_we),
        .waddr (mem_waddr),
        .wdata (pwm_wdata),
        .raddr (rd_addr),
        .rdata (pwm_q)
    );

    dot_mem #(.WIDTH(2), .DEPTH(NDOTS), .AW(8)) u_pat_mem (
        .clk   (clk),
        .we    (pat_we),
        .waddr (mem_waddr),
        .wdata (pat_wdata),
        .raddr (rd_addr),
        .rdata (pat_q)
    );

    reg [ROWS*8-1:0] row_pwm_r;
    reg [ROWS*2-1:0] row_pat_r;
    wire       cap   = state_r == ST_NOL && cnt_r >= 12'h001 &&
                       cnt_r <= ROWS;
    wire [3:0] cap_i = cnt_r[3:0] - 4'h1;

    // Capture latched one cycle after the address
    always @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            row_pwm_r <= {ROWS*8{1'b0}};
            row_pat_r <= {ROWS*2{1'b0}};
        end else if (cap) begin
            row_pwm_r[cap_i*8 +: 8] <= pwm_q;
            row_pat_r[cap_i*2 +: 2] <= pat_q;
        end
    end

    // ============================================================
    // Outputs: switches, row sources, anti-ghost selects
    wire in_slot = state_r == ST_SLOT && !clr_busy_r;
    reg  [ROWS-1:0] row_nxt;

    generate
        for (gi = 0; gi < ROWS; gi = gi + 1) begin : g_row
            always @* begin
                row_nxt[gi] = in_slot && !step_r[8] &&
                    step_r[7:0] < dot_level(row_pwm_r[gi*8 +: 8],
                        row_pat_r[gi*2 +: 2],
                        config_value[`CFG_BREATH_EN],
                        breath_level);
            end
        end
    endgenerate

    always @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            column_switch          <= {COLS{1'b0}};
            row_current_source     <= {ROWS{1'b0}};
            switch_pullup_select   <= 3'h0;
            source_pulldown_select <= 3'h0;
        end else begin
            column_switch <= (state_r == ST_SLOT) ?
                ({{(COLS-1){1'b0}}, 1'b1} << col_r) : {COLS{1'b0}};
            row_current_source <= row_nxt;
            // Pull resistors only while nothing conducts
            switch_pullup_select <= (state_r == ST_NOL) ?
                pullup_r : 3'h0;
            source_pulldown_select <= (state_r == ST_NOL) ?
                pulldown_r : 3'h0;
        end
    end

endmodule // led_matrix_scan_pwm

// [tb/host_model.sv]
// Host model that drives the decoded register port
`timescale 1ns/1ns
module host_model (
    input  wire       clk,
    output reg  [9:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        reg_wr,
    output reg        reg_rd,
    input  wire [7:0] reg_rdata
);
    // ============================================================
    // Idle values at time zero
    initial begin
        reg_addr  = 10'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // One-cycle write strobe; lines scrambled after release
    task wr(input [9:0] a, input [7:0] d);
        begin
            @(negedge clk);
            reg_addr  = a;
            reg_wdata = d;
            reg_wr    = 1'b1;
            @(negedge clk);
            reg_wr    = 1'b0;
            reg_addr  = ~a;
            reg_wdata = ~d;
        end
    endtask
    // Read strobe; data is taken one cycle later
    task rd(input [9:0] a, output [7:0] d);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_rd   = 1'b1;
            @(negedge clk);
            reg_rd   = 1'b0;
            reg_addr = ~a;
            d        = reg_rdata;
        end
    endtask
endmodule // host_model

// [tb/led_matrix_scan_pwm_asserts.sv]
// Port checks of the scanner and function registers
`timescale 1ns/1ns
module led_matrix_scan_pwm_asserts #(
    parameter COLS = 12,
    parameter ROWS = 16
) (
    input wire            clk,
    input wire            rst_n,
    input wire [9:0]      reg_addr,
    input wire [7:0]      reg_wdata,
    input wire            reg_wr,
    input wire            reg_rd,
    input wire [7:0]      reg_rdata,
    input wire [95:0]     breath_time_active,
    input wire [7:0]      config_value,
    input wire [7:0]      global_current_scale,
    input wire [COLS-1:0] column_switch,
    input wire [ROWS-1:0] row_current_source,
    input wire [2:0]      switch_pullup_select,
    input wire [2:0]      source_pulldown_select
);
    localparam int SLOT = 3200;
    localparam int NOL  = 200;
    reg  [11:0]     run_r;
    reg             act_r;
    reg             armed_r;
    reg  [COLS-1:0] last_r;
    wire            act = |column_switch;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // Length of the present on or off stretch; armed after a full one
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r   <= 12'h0;
            act_r   <= 1'b0;
            armed_r <= 1'b0;
            last_r  <= {COLS{1'b0}};
        end else begin
            run_r   <= (act != act_r) ? 12'h1 : run_r + 12'h1;
            act_r   <= act;
            armed_r <= armed_r | (act_r & ~act);
            last_r  <= act ? column_switch : last_r;
        end
    end
    // ============================================================
    // Scan timing
    a_onehot_cols: assert property ($onehot0(column_switch))
        else $error("column switches overlap");
    a_col_order: assert property (armed_r && !act_r && act |->
        column_switch == {last_r[COLS-2:0], last_r[COLS-1]})
        else $error("column order wrong");
    a_slot_len: assert property (armed_r && act_r && !act |->
        run_r == SLOT) else $error("slot length wrong");
    a_blank_len: assert property (armed_r && !act_r && act |->
        run_r == NOL) else $error("blanking length wrong");
    a_rows_slot: assert property (row_current_source != 0 |-> act)
        else $error("row on outside slot");
    a_pull_blank: assert property (switch_pullup_select != 0 ||
        source_pulldown_select != 0 |-> !act && row_current_source == 0)
        else $error("pull applied in slot");
    // ============================================================
    // Register port
    a_scale_write: assert property (reg_wr && reg_addr == 10'h301 |=>
        global_current_scale == $past(reg_wdata))
        else $error("scale not written");
    a_scale_read: assert property (reg_rd && reg_addr == 10'h301 |=>
        reg_rdata == $past(global_current_scale))
        else $error("scale read wrong");
    a_time_hold: assert property (!(reg_wr && reg_addr == 10'h30e &&
        reg_wdata == 8'h00) && !(reg_rd && reg_addr == 10'h311) |=>
        $stable(breath_time_active)) else $error("time changed early");
    a_soft_reset: assert property (reg_rd && reg_addr == 10'h311 |=>
        global_current_scale == 8'h00 && config_value == 8'h00 &&
        breath_time_active == 96'h0) else $error("soft reset missed");
endmodule // led_matrix_scan_pwm_asserts

bind led_matrix_scan_pwm led_matrix_scan_pwm_asserts #(
    .COLS(COLS), .ROWS(ROWS)) chk_u (.*);

// [tb/led_matrix_scan_pwm_test.sv]
// Self-checking bench of the matrix scanner and registers
`timescale 1ns/1ns
`include "led_matrix_defs.vh"
module led_matrix_scan_pwm_test;
    reg         clk;
    reg         rst_n;
    reg  [23:0] breath_level;
    wire [9:0]  reg_addr;
    wire [7:0]  reg_wdata, reg_rdata, config_value, global_current_scale;
    wire        reg_wr, reg_rd;
    wire [95:0] breath_time_active;
    wire [11:0] column_switch;
    wire [15:0] row_current_source;
    wire [2:0]  switch_pullup_select, source_pulldown_select;
    integer     failures, check_count, seed, i;
    reg  [7:0]  d, p;
    reg  [95:0] shadow;
    led_matrix_scan_pwm dut_u (.*);
    host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // ============================================================
    // Clock, expectations, compares and the verdict
    always #20 clk = ~clk;
    function [15:0] on_time(input [7:0] v);
        on_time = v * `PWM_PRE;
    endfunction
    task chk_val(input [127:0] nm, input [95:0] e, input [95:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("mismatch %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task chk_cnt(input [127:0] nm, input [15:0] e, input [15:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("mismatch %0s exp %0d got %0d", nm, e, g);
            end
        end
    endtask
    task test_done;
        begin
            if (failures == 0 && check_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Bounded wait until the OR of the masked column switches reaches level v
    task wait_cs(input [11:0] m, input v);
        integer k;
        begin
            k = 0;
            while ((|(column_switch & m)) !== v && k < 45000) begin
                @(negedge clk);
                k = k + 1;
            end
            if (k >= 45000) begin
                failures = failures + 1;
                test_done;
            end
        end
    endtask
    // Program one dot of the next column, count its row on-time there
    task dot_run(input [7:0] pv, input [1:0] pat, input wen,
                 input [15:0] e);
        integer c, r, k, cnt;
        reg [7:0] da;
        begin
            wait_cs(12'hfff, 1'b1);
            c = 0;
            for (k = 0; k < 12; k = k + 1)
                if (column_switch[k] === 1'b1) c = (k + 1) % 12;
            r = {$random(seed)} % 16;
            da = c * 16 + r;
            if (wen) begin
                host_u.wr({2'h1, da}, pv);
                host_u.wr({2'h2, da}, {6'h0, pat});
            end
            wait_cs(12'h1 << c, 1'b1);
            cnt = 0;
            k = 0;
            while (column_switch[c] === 1'b1 && k < 3400) begin
                cnt = cnt + row_current_source[r];
                @(negedge clk);
                k = k + 1;
            end
            if (k >= 3400) begin
                failures = failures + 1;
                test_done;
            end
            chk_cnt("row on time", e, cnt);
        end
    endtask
    // ============================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        breath_level = 24'h0;
        failures = 0;
        check_count = 0;
        seed = 97681;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        for (i = 0; i < 4; i = i + 1) begin
            host_u.rd((i < 2) ? 10'h300 + i : 10'h30d + i, d);
            chk_val("default reg", 0, d);
        end
        chk_val("time active", 0, breath_time_active);
        for (i = 0; i < 12; i = i + 1) begin
            d = $random(seed);
            shadow[i*8 +: 8] = d;
            host_u.wr(10'h302 + i, d);
        end
        chk_val("time active", 0, breath_time_active);
        host_u.rd(10'h307, d);
        chk_val("time shadow", shadow[47:40], d);
        host_u.wr(10'h30e, 8'h5a);
        chk_val("time active", 0, breath_time_active);
        host_u.wr(10'h30e, 8'h00);
        chk_val("time active", shadow, breath_time_active);
        d = $random(seed);
        host_u.wr(10'h301, d);
        host_u.rd(10'h301, p);
        chk_val("scale reg", d, p);
        chk_val("scale out", d, global_current_scale);
        host_u.rd(10'h312, p);
        chk_val("unmapped", 0, p);
        host_u.rd(10'h105, p);
        chk_val("dot page read", 0, p);
        // Every pull code, seen in blanking and dropped in the slot
        for (i = 0; i < 8; i = i + 1) begin
            host_u.wr(10'h30f, {5'h15, i[2:0]});
            host_u.wr(10'h310, 7 - i);
            host_u.rd(10'h30f, d);
            chk_val("pullup reg", i[2:0], d[2:0]);
            wait_cs(12'hfff, 1'b1);
            wait_cs(12'hfff, 1'b0);
            repeat (2) @(negedge clk);
            chk_val("pullup", i[2:0], switch_pullup_select);
            chk_val("pulldown", 7 - i, source_pulldown_select);
            wait_cs(12'hfff, 1'b1);
            repeat (2) @(negedge clk);
            chk_val("slot pulls", 0,
                {switch_pullup_select, source_pulldown_select});
        end
        // PWM steps with breathing off, nonzero patterns among them
        host_u.wr(10'h300, 8'h00);
        breath_level = $random(seed);
        dot_run(8'd0, 2'h1, 1'b1, on_time(8'd0));
        dot_run(8'd4, 2'h3, 1'b1, on_time(8'd4));
        dot_run(8'd255, 2'h0, 1'b1, on_time(8'd255));
        p = $random(seed);
        dot_run(p, 2'h2, 1'b1, on_time(p));
        // Breathing on: patterns follow their level, pattern 00 stays PWM
        host_u.wr(10'h300, 8'h02);
        dot_run(8'd13, 2'h1, 1'b1, on_time(breath_level[7:0]));
        dot_run(8'd13, 2'h3, 1'b1, on_time(breath_level[23:16]));
        dot_run(8'd13, 2'h2, 1'b1, on_time(breath_level[15:8]));
        dot_run(8'd13, 2'h0, 1'b1, on_time(8'd13));
        // Light every dot first, so the reset has something to clear
        for (i = 0; i < 192; i = i + 1) begin
            host_u.wr(10'h100 + i, 8'hff);
        end
        // Read-triggered reset of every register
        host_u.rd(10'h311, d);
        chk_val("config", 0, config_value);
        chk_val("scale out", 0, global_current_scale);
        chk_val("time active", 0, breath_time_active);
        host_u.rd(10'h30f, d);
        chk_val("pullup reg", 0, d);
        dot_run(8'd0, 2'h0, 1'b0, 16'd0);
        test_done;
    end
endmodule // led_matrix_scan_pwm_test
